//--- core/timer_pkg.sv
package timer_pkg;

    localparam int NUM_CH     = 6;
    localparam int GR_PER_CH  = 4;
    localparam int NUM_TABLES = 3;
    localparam int IO_FIELD_W = 4;
    localparam int CTRL_W     = 11;

    // Channel capability masks, bit n is channel n
    localparam logic [NUM_CH-1:0] BUF_CH   = 6'h09;
    localparam logic [NUM_CH-1:0] PHASE_CH = 6'h36;
    localparam logic [NUM_CH-1:0] UPPER_CH = 6'h12;
    localparam logic [NUM_CH-1:0] UDF_CH   = 6'h36;

    // Byte offsets inside one channel window, and the table window
    localparam logic [7:0] CH_STRIDE  = 8'h20;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_IO     = 8'h04;
    localparam logic [7:0] OFF_COUNT  = 8'h08;
    localparam logic [7:0] OFF_GR_A   = 8'h0c;
    localparam logic [7:0] OFF_GR_D   = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1c;
    localparam logic [7:0] OFF_TABLE  = 8'hc0;

    localparam logic [2:0] IDX_CTRL   = OFF_CTRL[4:2];
    localparam logic [2:0] IDX_IO     = OFF_IO[4:2];
    localparam logic [2:0] IDX_COUNT  = OFF_COUNT[4:2];
    localparam logic [2:0] IDX_GR_A   = OFF_GR_A[4:2];
    localparam logic [2:0] IDX_GR_D   = OFF_GR_D[4:2];
    localparam logic [2:0] IDX_STATUS = OFF_STATUS[4:2];
    localparam logic [2:0] TABLE_WIN  = OFF_TABLE[7:5];

    // Per-register io field: bit 3 capture, bits 1:0 edge or action
    localparam int IO_CAP_BIT = 3;
    localparam int EDGE_RISE  = 0;
    localparam int EDGE_FALL  = 1;
    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_LOW    = 2'h1;
    localparam logic [1:0] ACT_HIGH   = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    localparam int ST_OVF = 4;
    localparam int ST_UDF = 5;

    localparam logic [2:0]  PH_OFF  = 3'h0;
    localparam logic [2:0]  PH_ONE  = 3'h1;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // Mode one decode, index {a_prev, b_prev, a, b}
    localparam logic [31:0] MODE1_TABLE = 32'h4182_2814;

    localparam logic [15:0] IO_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] GR_RESET    = 16'hffff;
    localparam logic [31:0] TABLE_RESET = 32'h0000_0000;

    typedef struct packed {
        logic       run;
        logic [2:0] phase_mode;
        logic       cascade;
        logic       buf_en;
        logic       pwm1;
        logic       sync_en;
        logic [2:0] clr_sel;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '0;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
    } bus_req_t;

endpackage

//--- core/edge_sync.sv
`timescale 1ns/100ps
module edge_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] prev_r;

    // Edges compare the second stage with a third; first stage stays private
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;

endmodule

//--- core/phase_decoder.sv
`timescale 1ns/100ps
module phase_decoder (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        a,
    input  wire logic        b,
    input  wire logic [15:0] up_mask,
    input  wire logic [15:0] down_mask,
    output logic             up,
    output logic             down
);

    logic [1:0] prev_r;
    logic       valid_r;
    logic [3:0] idx;
    logic       moved;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r  <= 2'h0;
            valid_r <= 1'b0;
        end else begin
            prev_r  <= {a, b};
            valid_r <= 1'b1;
        end
    end

    // First sample after reset seeds history with the synchronizer's reset 00, so a pin high at reset reads as a move from 00
    always_comb begin
        idx   = {prev_r, a, b};
        moved = valid_r && (prev_r != {a, b});
        up    = moved && up_mask[idx] && !down_mask[idx];
        down  = moved && down_mask[idx] && !up_mask[idx];
    end

endmodule

//--- core/capture_compare_timer.sv
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module capture_compare_timer
    import timer_pkg::*;
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic      [31:0]            hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic [NUM_CH-1:0][3:0] timer_io_pin_in,
    output logic      [NUM_CH-1:0][3:0] timer_io_pin_out,
    output logic      [NUM_CH-1:0][3:0] timer_io_pin_oe,
    input  wire logic                   phase_clock_in_a,
    input  wire logic                   phase_clock_in_b,
    input  wire logic                   phase_clock_in_c,
    input  wire logic                   phase_clock_in_d,
    output logic      [NUM_CH-1:0][5:0] timer_request
);

    bus_req_t                  req_r;
    bus_req_t                  req_nxt;
    logic [31:0]               hrdata_r;
    logic [31:0]               hrdata_nxt;
    logic [31:0]               rd_val;
    logic [2:0]                rc;
    logic [2:0]                ri;

    ctrl_t [NUM_CH-1:0]        ctrl_r;
    ctrl_t [NUM_CH-1:0]        ctrl_nxt;
    logic [NUM_CH-1:0][15:0]   io_r;
    logic [NUM_CH-1:0][15:0]   io_nxt;
    logic [NUM_CH-1:0][15:0]   cnt_r;
    logic [NUM_CH-1:0][15:0]   cnt_nxt;
    logic [NUM_CH-1:0][3:0][15:0] gr_r;
    logic [NUM_CH-1:0][3:0][15:0] gr_nxt;
    logic [NUM_CH-1:0][5:0]    flag_r;
    logic [NUM_CH-1:0][5:0]    flag_nxt;
    logic [NUM_CH-1:0][3:0]    pin_r;
    logic [NUM_CH-1:0][3:0]    pin_nxt;
    logic [NUM_CH-1:0]         moved_r;
    logic [NUM_CH-1:0]         moved_nxt;
    logic [NUM_TABLES-1:0][31:0] tbl_r;
    logic [NUM_TABLES-1:0][31:0] tbl_nxt;

    logic [NUM_CH-1:0][3:0]    pin_rise;
    logic [NUM_CH-1:0][3:0]    pin_fall;
    logic [3:0]                ph_lvl;
    logic [NUM_CH-1:0]         ph_up;
    logic [NUM_CH-1:0]         ph_dn;

    logic [NUM_CH:0]           up;
    logic [NUM_CH:0]           dn;
    logic [NUM_CH:0]           ovf;
    logic [NUM_CH:0]           udf;
    logic [NUM_CH-1:0][3:0]    live;
    logic [NUM_CH-1:0][3:0]    cap;
    logic [NUM_CH-1:0][3:0]    mat;
    logic [NUM_CH-1:0]         clr;
    logic                      sync_clr;
    logic [3:0]                fld;
    logic [3:0]                sfld;
    logic [2:0]                wc;
    logic [2:0]                wi;
    logic [15:0]               wdat;

    edge_sync #(.WIDTH(NUM_CH*4)) u_pin_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .din   (timer_io_pin_in),
        .level (),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    edge_sync #(.WIDTH(4)) u_phase_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .din   ({phase_clock_in_d, phase_clock_in_c, phase_clock_in_b, phase_clock_in_a}),
        .level (ph_lvl),
        .rise  (),
        .fall  ()
    );

    // Channels 2 and 4 listen to the c/d pair, the rest to a/b
    for (genvar c = 0; c < NUM_CH; c++) begin : g_phase
        localparam int PA = (c == 2 || c == 4) ? 2 : 0;
        logic [31:0] tbl;

        always_comb begin
            unique case (ctrl_r[c].phase_mode)
                3'h2:    tbl = tbl_r[0];
                3'h3:    tbl = tbl_r[1];
                3'h4:    tbl = tbl_r[2];
                default: tbl = MODE1_TABLE;
            endcase
        end

        phase_decoder u_dec (
            .clk       (hclk),
            .rst_n     (hresetn),
            .a         (ph_lvl[PA]),
            .b         (ph_lvl[PA+1]),
            .up_mask   (tbl[15:0]),
            .down_mask (tbl[31:16]),
            .up        (ph_up[c]),
            .down      (ph_dn[c])
        );
    end

    // Reads take one wait state so a write just before is always visible
    always_comb begin
        req_nxt.rd   = hsel && htrans[1] && hready && !hwrite;
        req_nxt.wr   = hsel && htrans[1] && hready && hwrite;
        req_nxt.addr = (hsel && htrans[1] && hready) ? haddr[7:0] : req_r.addr;
        rc           = req_r.addr[7:5];
        ri           = req_r.addr[4:2];
        rd_val       = '0;
        if (rc < 3'(NUM_CH)) begin
            if (ri == IDX_CTRL) begin
                rd_val[CTRL_W-1:0] = ctrl_r[rc];
            end else if (ri == IDX_IO) begin
                rd_val[15:0] = io_r[rc];
            end else if (ri == IDX_COUNT) begin
                rd_val[15:0] = cnt_r[rc];
            end else if (ri == IDX_STATUS) begin
                rd_val[5:0] = flag_r[rc];
            end else if (BUF_CH[rc] || ri < IDX_GR_A + 3'h2) begin
                rd_val[15:0] = gr_r[rc][2'(ri - IDX_GR_A)];
            end
        end else if (rc == TABLE_WIN && ri < 3'(NUM_TABLES)) begin
            rd_val = tbl_r[ri[1:0]];
        end
        hrdata_nxt = req_r.rd ? rd_val : hrdata_r;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r    <= '0;
            hrdata_r <= 32'h0000_0000;
        end else begin
            req_r    <= req_nxt;
            hrdata_r <= hrdata_nxt;
        end
    end

    assign hrdata    = hrdata_r;
    assign hreadyout = !req_r.rd;
    assign hresp     = 1'b0;

    always_comb begin
        ctrl_nxt = ctrl_r;
        io_nxt   = io_r;
        cnt_nxt  = cnt_r;
        gr_nxt   = gr_r;
        flag_nxt = flag_r;
        pin_nxt  = pin_r;
        tbl_nxt  = tbl_r;
        up       = '0;
        dn       = '0;
        ovf      = '0;
        udf      = '0;
        live     = '0;
        cap      = '0;
        mat      = '0;
        clr      = '0;
        sync_clr = 1'b0;
        fld      = '0;
        sfld     = '0;
        wc       = req_r.addr[7:5];
        wi       = req_r.addr[4:2];
        wdat     = hwdata[15:0];

        // Lower cascade channel sits above its upper one, so walk downward
        for (int c = NUM_CH - 1; c >= 0; c--) begin
            if (!ctrl_r[c].run) begin
                up[c] = 1'b0;
            end else if (PHASE_CH[c] && ctrl_r[c].phase_mode != PH_OFF) begin
                up[c] = ph_up[c];
                dn[c] = ph_dn[c];
            end else if (UPPER_CH[c] && ctrl_r[c].cascade) begin
                up[c] = ovf[c+1];
                dn[c] = udf[c+1];
            end else begin
                up[c] = 1'b1;
            end
            ovf[c] = up[c] && cnt_r[c] == CNT_MAX;
            udf[c] = dn[c] && cnt_r[c] == COUNT_RESET;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            for (int i = 0; i < GR_PER_CH; i++) begin
                fld        = io_r[c][IO_FIELD_W*i +: IO_FIELD_W];
                live[c][i] = (i < 2) || (BUF_CH[c] && !ctrl_r[c].buf_en);
                if (fld[IO_CAP_BIT]) begin
                    cap[c][i] = live[c][i] && ((fld[EDGE_RISE] && pin_rise[c][i])
                                || (fld[EDGE_FALL] && pin_fall[c][i]));
                end else begin
                    mat[c][i] = live[c][i] && moved_r[c] && cnt_r[c] == gr_r[c][i];
                end
            end
            if (ctrl_r[c].clr_sel != 3'h0 && ctrl_r[c].clr_sel <= 3'h4) begin
                clr[c] = cap[c][2'(ctrl_r[c].clr_sel - 3'h1)]
                       | mat[c][2'(ctrl_r[c].clr_sel - 3'h1)];
            end
            sync_clr = sync_clr | (clr[c] && ctrl_r[c].sync_en);
        end

        for (int c = 0; c < NUM_CH; c++) begin
            if (clr[c] || (sync_clr && ctrl_r[c].sync_en)) begin
                cnt_nxt[c] = COUNT_RESET;
            end else if (up[c]) begin
                cnt_nxt[c] = cnt_r[c] + 16'h0001;
            end else if (dn[c]) begin
                cnt_nxt[c] = cnt_r[c] - 16'h0001;
            end

            // Each channel captures on its own pin edge; buffered A/B push their old value into C/D
            for (int i = 0; i < GR_PER_CH; i++) begin
                if (cap[c][i]) begin
                    gr_nxt[c][i] = cnt_r[c];
                    if (i < 2 && BUF_CH[c] && ctrl_r[c].buf_en) begin
                        gr_nxt[c][2'(i + 2)] = gr_r[c][i];
                    end
                end else if (mat[c][i] && i < 2 && BUF_CH[c] && ctrl_r[c].buf_en) begin
                    gr_nxt[c][i] = gr_r[c][2'(i + 2)];
                end
            end

            // In PWM one an even pin also obeys its odd partner; the odd register wins a tie
            for (int p = 0; p < GR_PER_CH; p++) begin
                for (int s = p; s <= p + 1 && s < GR_PER_CH; s++) begin
                    sfld = io_r[c][IO_FIELD_W*s +: IO_FIELD_W];
                    if (mat[c][s] && (s == p || (ctrl_r[c].pwm1 && p % 2 == 0))) begin
                        unique case (sfld[1:0])
                            ACT_NONE:   pin_nxt[c][p] = pin_nxt[c][p];
                            ACT_LOW:    pin_nxt[c][p] = 1'b0;
                            ACT_HIGH:   pin_nxt[c][p] = 1'b1;
                            ACT_TOGGLE: pin_nxt[c][p] = ~pin_nxt[c][p];
                        endcase
                    end
                end
            end

            // Only a set on a clear flag wins over a same-cycle write-one clear
            flag_nxt[c][3:0] = flag_r[c][3:0] | ((cap[c] | mat[c]) & live[c]);
            flag_nxt[c][ST_OVF] = flag_r[c][ST_OVF] | ovf[c];
            flag_nxt[c][ST_UDF] = flag_r[c][ST_UDF] | (udf[c] && UDF_CH[c]);
            if (req_r.wr && wc == 3'(c) && wi == IDX_STATUS) begin
                flag_nxt[c] = (flag_r[c] & ~hwdata[5:0]) | (flag_nxt[c] & ~flag_r[c]);
            end
        end

        if (req_r.wr && wc < 3'(NUM_CH)) begin
            if (wi == IDX_CTRL) begin
                ctrl_nxt[wc] = hwdata[CTRL_W-1:0];
                if (!BUF_CH[wc]) begin
                    ctrl_nxt[wc].buf_en = 1'b0;
                end
                if (!PHASE_CH[wc]) begin
                    ctrl_nxt[wc].phase_mode = PH_OFF;
                end
                if (!UPPER_CH[wc]) begin
                    ctrl_nxt[wc].cascade = 1'b0;
                end
            end else if (wi == IDX_IO) begin
                io_nxt[wc] = wdat;
            end else if (wi == IDX_COUNT) begin
                for (int k = 0; k < NUM_CH; k++) begin
                    if (3'(k) == wc || (ctrl_r[wc].sync_en && ctrl_r[k].sync_en)) begin
                        cnt_nxt[k] = wdat;
                    end
                end
            end else if (wi >= IDX_GR_A && wi <= IDX_GR_D) begin
                if (wi < IDX_GR_A + 3'h2 || BUF_CH[wc]) begin
                    gr_nxt[wc][2'(wi - IDX_GR_A)] = wdat;
                end
            end
        end else if (req_r.wr && wc == TABLE_WIN && wi < 3'(NUM_TABLES)) begin
            tbl_nxt[wi[1:0]] = hwdata;
        end

        for (int c = 0; c < NUM_CH; c++) begin
            moved_nxt[c] = cnt_nxt[c] != cnt_r[c];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r  <= {NUM_CH{CTRL_RESET}};
            io_r    <= {NUM_CH{IO_RESET}};
            cnt_r   <= {NUM_CH{COUNT_RESET}};
            gr_r    <= {NUM_CH*GR_PER_CH{GR_RESET}};
            flag_r  <= '0;
            pin_r   <= '0;
            moved_r <= '0;
            tbl_r   <= {NUM_TABLES{TABLE_RESET}};
        end else begin
            ctrl_r  <= ctrl_nxt;
            io_r    <= io_nxt;
            cnt_r   <= cnt_nxt;
            gr_r    <= gr_nxt;
            flag_r  <= flag_nxt;
            pin_r   <= pin_nxt;
            moved_r <= moved_nxt;
            tbl_r   <= tbl_nxt;
        end
    end

    // Odd pins in PWM one are idle; their register only sets the edge
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            for (int p = 0; p < GR_PER_CH; p++) begin
                timer_io_pin_oe[c][p] = live[c][p]
                    && !io_r[c][IO_FIELD_W*p + IO_CAP_BIT]
                    && (ctrl_r[c].pwm1 ? (p % 2 == 0)
                                       : io_r[c][IO_FIELD_W*p +: 2] != ACT_NONE);
            end
        end
    end

    assign timer_io_pin_out = pin_r;
    assign timer_request    = flag_r;

endmodule

//--- verification/capture_compare_timer_chk.sv
`timescale 1ns/100ps
module capture_compare_timer_chk
    import timer_pkg::*;
(
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [2:0]             hsize,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic [NUM_CH-1:0][3:0] timer_io_pin_in,
    input wire logic [NUM_CH-1:0][3:0] timer_io_pin_out,
    input wire logic [NUM_CH-1:0][3:0] timer_io_pin_oe,
    input wire logic                   phase_clock_in_a,
    input wire logic                   phase_clock_in_b,
    input wire logic                   phase_clock_in_c,
    input wire logic                   phase_clock_in_d,
    input wire logic [NUM_CH-1:0][5:0] timer_request
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_take;
    logic wr_take;
    assign rd_take = hsel & htrans[1] & hready & ~hwrite;
    assign wr_take = hsel & htrans[1] & hready & hwrite;
    sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
    property p_rd; rd_take |=> s_one_wait; endproperty
    a_rd: assert property (p_rd) else $error("read wait state not one cycle");
    property p_wr; wr_take |=> hreadyout; endproperty
    a_wr: assert property (p_wr) else $error("write data phase stalled");
    property p_wait; !hreadyout |-> $past(rd_take); endproperty
    a_wait: assert property (p_wait) else $error("wait state without a read");
    property p_hold; $past(hreadyout) |-> $stable(hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved outside a read");
    property p_okay; !hresp; endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    // Flags only drop through a status write two edges earlier
    property p_sticky;
        |($past(timer_request) & ~timer_request) |-> $past(wr_take, 2);
    endproperty
    a_sticky: assert property (p_sticky) else $error("request flag lost");
    property p_udf; !timer_request[0][ST_UDF] && !timer_request[3][ST_UDF]; endproperty
    a_udf: assert property (p_udf) else $error("underflow on channel 0 or 3");
    property p_cd;
        (timer_request[1][3:2] | timer_request[2][3:2] | timer_request[4][3:2]
         | timer_request[5][3:2]) == 2'h0;
    endproperty
    a_cd: assert property (p_cd) else $error("C or D request on two-register channel");
endmodule

bind capture_compare_timer capture_compare_timer_chk u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .timer_io_pin_in, .timer_io_pin_out, .timer_io_pin_oe,
    .phase_clock_in_a, .phase_clock_in_b, .phase_clock_in_c, .phase_clock_in_d,
    .timer_request
);

//--- verification/pin_model.sv
`timescale 1ns/100ps
module pin_model (
    input  wire logic            hclk,
    input  wire logic [5:0][3:0] pin_out,
    input  wire logic [5:0][3:0] pin_oe,
    output logic      [5:0][3:0] pin_level,
    output logic                 ph_a,
    output logic                 ph_b
);
    logic [5:0][3:0] drv = '0;
    logic [1:0]      pos = 2'h0;
    // Timer wins the wire while it drives
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & drv);
    initial begin
        ph_a = 1'b0;
        ph_b = 1'b0;
    end
    // Six clocks, well above the two-clock minimum pulse
    task automatic lvl(input logic [5:0][3:0] v);
        drv <= v;
        repeat (6) @(posedge hclk);
    endtask
    // Gray step, never both phases at once
    task automatic step(input logic up);
        pos = up ? pos + 2'h1 : pos - 2'h1;
        ph_a <= pos[1] ^ pos[0];
        ph_b <= pos[1];
        repeat (3) @(posedge hclk);
    endtask
endmodule

//--- verification/tb_multichannel_capture_compare_timer.sv
`timescale 1ns/100ps
module tb_multichannel_capture_compare_timer
    import timer_pkg::*;
;
    logic                   hclk = 1'b0;
    logic                   hresetn = 1'b0;
    logic                   hsel = 1'b0;
    logic [31:0]            haddr = '0;
    logic [1:0]             htrans = 2'h0;
    logic                   hwrite = 1'b0;
    logic [31:0]            hwdata = '0;
    logic [31:0]            hrdata;
    logic                   hreadyout;
    logic [NUM_CH-1:0][3:0] pin_out;
    logic [NUM_CH-1:0][3:0] pin_oe;
    logic [NUM_CH-1:0][3:0] pin_lvl;
    logic [NUM_CH-1:0][3:0] pv = '0;
    logic [NUM_CH-1:0][5:0] req;
    logic                   ph_a;
    logic                   ph_b;
    logic [31:0]            q;
    int                     error_cnt = 0;
    int                     check_count = 0;
    int                     cyc = 0;

    always #2 hclk = ~hclk;

    capture_compare_timer DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .timer_io_pin_in(pin_lvl),
        .timer_io_pin_out(pin_out), .timer_io_pin_oe(pin_oe), .phase_clock_in_a(ph_a),
        .phase_clock_in_b(ph_b), .phase_clock_in_c(ph_a), .phase_clock_in_d(ph_b),
        .timer_request(req)
    );
    pin_model pm (.hclk, .pin_out, .pin_oe, .pin_level(pin_lvl), .ph_a, .ph_b);

    task automatic end_sim();
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    function automatic logic [7:0] ad(input int ch, input logic [7:0] off);
        return 8'(ch) * CH_STRIDE + off;
    endfunction
    task automatic wr(input int ch, input logic [7:0] off, input logic [31:0] d);
        bus(1'b1, ad(ch, off), d);
    endtask
    task automatic rc(input int ch, input logic [7:0] off, input logic [31:0] e);
        bus(1'b0, ad(ch, off), 32'h0);
        chk(q, e);
    endtask
    task automatic pin(input int ch, input logic v);
        pv[ch][0] = v;
        pm.lvl(pv);
    endtask
    task automatic wait_pin(input int ch, input logic v, output int n);
        n = 0;
        while (pin_out[ch][0] !== v && n < 300) begin
            @(posedge hclk);
            n++;
        end
    endtask

    task automatic t_regs();
        rc(0, OFF_GR_A, 32'hffff);
        wr(1, OFF_GR_D, 32'h1234);
        rc(1, OFF_GR_D, 32'h0);
        rc(6, 8'h0c, 32'h0);
        wr(6, 8'h04, 32'h0001_0002);
        rc(6, 8'h04, 32'h0001_0002);
        wr(0, OFF_CTRL, 32'h0c0);
        rc(0, OFF_CTRL, 32'h0);
    endtask
    task automatic t_capture();
        logic [15:0] e = 16'hffff;
        for (int c = 1; c < 4; c++) begin
            wr(0, OFF_IO, 32'(8 + c));
            wr(0, OFF_COUNT, 32'(c * 256));
            pin(0, 1'b1);
            if (c[0]) e = 16'(c * 256);
            rc(0, OFF_GR_A, {16'h0, e});
            wr(0, OFF_COUNT, 32'(c * 256 + 1));
            pin(0, 1'b0);
            if (c[1]) e = 16'(c * 256 + 1);
            rc(0, OFF_GR_A, {16'h0, e});
        end
        chk(req[0][0], 1'b1);
        wr(0, OFF_STATUS, 32'h1);
        @(posedge hclk);
        chk(req[0][0], 1'b0);
        wr(0, OFF_CTRL, 32'h1);
        wr(0, OFF_COUNT, 32'h3333);
        pin(0, 1'b1);
        rc(0, OFF_COUNT, 32'h0);
        rc(0, OFF_GR_A, 32'h3333);
    endtask
    task automatic t_buffer();
        wr(3, OFF_CTRL, 32'h20);
        wr(3, OFF_IO, 32'h9);
        wr(3, OFF_COUNT, 32'h55);
        pin(3, 1'b1);
        rc(3, OFF_GR_A, 32'h55);
        rc(3, OFF_GR_A + 8'h8, 32'hffff);
        wr(3, OFF_COUNT, 32'h77);
        pin(3, 1'b0);
        pin(3, 1'b1);
        rc(3, OFF_GR_A, 32'h77);
        rc(3, OFF_GR_A + 8'h8, 32'h55);
    endtask
    task automatic t_pwm();
        int n1;
        int n2;
        wr(0, OFF_IO, 32'h12);
        wr(0, OFF_GR_A, 32'h10);
        wr(0, OFF_GR_A + 8'h4, 32'h40);
        wr(0, OFF_GR_A + 8'h8, 32'h30);
        wr(0, OFF_GR_D, 32'h40);
        wr(0, OFF_COUNT, 32'h0);
        wr(0, OFF_CTRL, 32'h432);
        wait_pin(0, 1'b1, n1);
        wait_pin(0, 1'b0, n1);
        wait_pin(0, 1'b1, n2);
        wait_pin(0, 1'b0, n2);
        chk(32'(n1), 32'h30);
        chk(32'(n2), 32'h10);
        chk(pin_oe[0][0], 1'b1);
        wr(0, OFF_CTRL, 32'h0);
        rc(0, OFF_GR_A, 32'h30);
        wr(1, OFF_IO, 32'h3);
        wr(1, OFF_GR_A, 32'h8);
        wr(1, OFF_CTRL, 32'h400);
        wait_pin(1, 1'b1, n1);
        repeat (50) @(posedge hclk);
        chk(32'(n1 < 30), 32'h1);
        chk(pin_out[1][0], 1'b1);
    endtask
    task automatic t_phase();
        // Mode two table is mode one reversed, on the c/d pair
        wr(6, 8'h00, 32'h2814_4182);
        wr(2, OFF_CTRL, 32'h500);
        wr(1, OFF_CTRL, 32'h480);
        wr(1, OFF_IO, 32'h0);
        wr(1, OFF_COUNT, 32'h0);
        repeat (8) pm.step(1'b1);
        rc(1, OFF_COUNT, 32'h8);
        repeat (11) pm.step(1'b0);
        rc(1, OFF_COUNT, 32'hfffd);
        rc(2, OFF_COUNT, 32'h3);
        chk(req[2][ST_OVF], 1'b1);
        chk(req[1][ST_UDF], 1'b1);
        wr(1, OFF_STATUS, 32'h20);
        @(posedge hclk);
        chk(req[1][ST_UDF], 1'b0);
    endtask
    task automatic t_cascade_sync();
        logic [31:0] e;
        wr(1, OFF_CTRL, 32'h440);
        wr(1, OFF_COUNT, 32'h7);
        wr(1, OFF_IO, 32'h9);
        wr(2, OFF_IO, 32'h9);
        wr(2, OFF_COUNT, 32'hfffe);
        wr(2, OFF_CTRL, 32'h400);
        repeat (4) @(posedge hclk);
        wr(2, OFF_CTRL, 32'h0);
        rc(1, OFF_COUNT, 32'h8);
        // Six counts from fffe before the stop lands
        e = 32'h4;
        rc(2, OFF_COUNT, e);
        pv[1][0] = 1'b1;
        pin(2, 1'b1);
        rc(1, OFF_GR_A, 32'h8);
        rc(2, OFF_GR_A, e);
        pin(3, 1'b0);
        wr(0, OFF_CTRL, 32'h8);
        wr(3, OFF_CTRL, 32'h9);
        wr(0, OFF_COUNT, 32'habc);
        rc(3, OFF_COUNT, 32'habc);
        rc(2, OFF_COUNT, e);
        pin(3, 1'b1);
        rc(0, OFF_COUNT, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_capture();
        t_buffer();
        t_pwm();
        t_phase();
        t_cascade_sync();
        end_sim();
    end
endmodule
